// *** rtl/rscl_pkg.sv ***
// Purpose: shared constants and carrier types for the strap configuration loader
// Assumes: 32-bit AXI4-Lite register port, 125 MHz aclk
// Notes: register words keep their management-register bit positions in the low 16 bits
package rscl_pkg;

  // register byte offsets
  localparam logic [5:0] CTRL_OFF = 6'h00;
  localparam logic [5:0] ADV_OFF = 6'h04;
  localparam logic [5:0] SMODE_OFF = 6'h08;
  localparam logic [5:0] STRAP_OFF = 6'h0c;
  localparam int ADDR_W = 6;

  // control register field positions
  localparam int CTRL_SOFT_RST_BIT = 15;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_ANEN_BIT = 12;
  localparam int CTRL_ISO_BIT = 10;
  localparam int CTRL_DUPLEX_BIT = 8;

  // advertisement field: bits 8..5
  localparam int ADV_LSB = 5;

  // special modes field positions
  localparam int SMODE_ADDR_LSB = 0;
  localparam int SMODE_MODE_LSB = 5;
  localparam int SMODE_IFACE_BIT = 14;

  // strap readback field positions
  localparam int STRAP_ADDR_LSB = 0;
  localparam int STRAP_MODE_LSB = 4;
  localparam int STRAP_IFACE_BIT = 8;

  // reset values, control nibble is {13,12,10,8}
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [3:0] ADV_RST = 4'hf;
  localparam logic [2:0] ADDR_RST = 3'h0;
  localparam logic [2:0] MODE_RST = 3'h0;

  // operating mode strap encodings
  localparam logic [2:0] MODE_10HD = 3'h0;
  localparam logic [2:0] MODE_10FD = 3'h1;
  localparam logic [2:0] MODE_100HD = 3'h2;
  localparam logic [2:0] MODE_100FD = 3'h3;
  localparam logic [2:0] MODE_AN_100HD = 3'h4;
  localparam logic [2:0] MODE_REPEATER = 3'h5;
  localparam logic [2:0] MODE_PDOWN = 3'h6;
  localparam logic [2:0] MODE_ALL = 3'h7;

  // control nibble and advertisement loads per mode
  localparam logic [3:0] CTRL_LD_10HD = 4'h0;
  localparam logic [3:0] CTRL_LD_10FD = 4'h1;
  localparam logic [3:0] CTRL_LD_100HD = 4'h8;
  localparam logic [3:0] CTRL_LD_100FD = 4'h9;
  localparam logic [3:0] CTRL_LD_AN = 4'hc;
  localparam logic [3:0] CTRL_LD_ALL = 4'hd;
  localparam logic [3:0] ADV_LD_100HD = 4'h4;
  localparam logic [3:0] ADV_LD_ALL = 4'hf;

  // cycles after power-on release before the strap synchronisers are trusted
  localparam logic [1:0] SYNC_SETTLE = 2'h3;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic iface;
    logic [2:0] mode;
    logic [2:0] addr;
  } rscl_strap_type;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic an_enable;
    logic isolate;
    logic crs_on_tx;
    logic repeater;
    logic powered_down;
    logic rmii_mode;
    logic [4:0] station_addr;
  } rscl_cfg_type;

endpackage

// *** rtl/rscl_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are quasi-static pins
// Notes: first stage is read only by the second
module rscl_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // next stage values, frozen with clk_en
  always_comb begin
    meta_nxt = clk_en ? d : meta_r;
    q_nxt = clk_en ? meta_r : q_r;
  end

  // register both stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

// *** rtl/rscl_addr_match.sv ***
// Purpose: compares management frame address with the station address
// Assumes: frame address strobe comes from logic on aclk
// Notes: match answer is registered, one cycle after the strobe
module rscl_addr_match (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic frame_valid,
  input wire logic [4:0] frame_addr,
  input wire logic [4:0] station_addr,
  output logic match,
  output logic miss
);
  logic match_r;
  logic match_nxt;
  logic miss_r;
  logic miss_nxt;

  // pulse one of the two answers per frame strobe
  always_comb begin
    match_nxt = match_r;
    miss_nxt = miss_r;
    if (clk_en) begin
      match_nxt = frame_valid && (frame_addr == station_addr);
      miss_nxt = frame_valid && (frame_addr != station_addr);
    end
  end

  // answer flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_r <= 1'b0;
      miss_r <= 1'b0;
    end else begin
      match_r <= match_nxt;
      miss_r <= miss_nxt;
    end
  end

  assign match = match_r;
  assign miss = miss_r;
endmodule

// *** rtl/rscl_top.sv ***
// Purpose: strap capture and configuration register loader with AXI4-Lite access
// Assumes: aresetn is power-on reset, external_reset_pin_n and straps are asynchronous pins
// Notes: all outputs come from flops; clk_en low freezes every flop
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
module rscl_top
  import rscl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // board pins
  input wire logic external_reset_pin_n,
  input wire logic [2:0] address_straps,
  input wire logic [2:0] mode_straps,
  input wire logic interface_select_strap,
  // management frame address from the serial decoder
  input wire logic mgmt_frame_valid,
  input wire logic [4:0] mgmt_frame_addr,
  output logic mgmt_frame_match,
  output logic mgmt_frame_miss,
  // resulting configuration
  output rscl_pkg::rscl_cfg_type cfg,
  output logic [4:0] scrambler_seed,
  output logic strap_load_pulse,
  // AXI4-Lite slave
  input wire logic [rscl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rscl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic [1:0] {LD_POR, LD_HOLD, LD_RUN} rscl_ld_type;

  // synchronised pins
  logic pin_rst_n_s;
  logic [6:0] strap_s;
  rscl_strap_type strap_now;

  // loader state
  rscl_ld_type ld_r, ld_nxt;
  logic [1:0] settle_r, settle_nxt;
  logic capture;
  rscl_strap_type strap_r, strap_nxt;
  logic load_r, load_nxt;

  // register contents
  logic [3:0] ctrl4_r, ctrl4_nxt;
  logic [3:0] adv4_r, adv4_nxt;
  logic [4:0] saddr_r, saddr_nxt;
  logic [2:0] smode_r, smode_nxt;
  logic iface_r, iface_nxt;
  logic pdown_r, pdown_nxt;
  rscl_cfg_type cfg_r, cfg_nxt;
  logic soft_rst;

  // bus slave state
  logic aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_write;
  logic [31:0] wr_word;

  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // register word images, reserved bits read zero
  function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a, input logic [3:0] c,
                                           input logic [3:0] adv, input logic [4:0] sa,
                                           input logic [2:0] sm, input logic ifc,
                                           input rscl_strap_type st);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      CTRL_OFF: begin
        w[CTRL_SPEED_BIT] = c[3];
        w[CTRL_ANEN_BIT] = c[2];
        w[CTRL_ISO_BIT] = c[1];
        w[CTRL_DUPLEX_BIT] = c[0];
      end
      ADV_OFF: w[ADV_LSB +: 4] = adv;
      SMODE_OFF: begin
        w[SMODE_ADDR_LSB +: 5] = sa;
        w[SMODE_MODE_LSB +: 3] = sm;
        w[SMODE_IFACE_BIT] = ifc;
      end
      STRAP_OFF: begin
        w[STRAP_ADDR_LSB +: 3] = st.addr;
        w[STRAP_MODE_LSB +: 3] = st.mode;
        w[STRAP_IFACE_BIT] = st.iface;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a == CTRL_OFF) || (a == ADV_OFF) || (a == SMODE_OFF) || (a == STRAP_OFF);
  endfunction

  // straps and reset pin are off-domain: two flops before any use
  rscl_sync #(.W(1)) u_rst_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .d(external_reset_pin_n),
    .q(pin_rst_n_s)
  );

  rscl_sync #(.W(7)) u_strap_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .d({interface_select_strap, mode_straps, address_straps}),
    .q(strap_s)
  );

  assign strap_now = rscl_strap_type'(strap_s);

  // loader: capture after power-on settle and on every pin reset release
  always_comb begin
    ld_nxt = ld_r;
    settle_nxt = settle_r;
    capture = 1'b0;
    if (clk_en) begin
      unique case (ld_r)
        LD_POR: begin
          if (settle_r != SYNC_SETTLE) begin
            settle_nxt = settle_r + 2'h1;
          end else if (!pin_rst_n_s) begin
            ld_nxt = LD_HOLD;
          end else begin
            capture = 1'b1;
            ld_nxt = LD_RUN;
          end
        end
        LD_HOLD: begin
          if (pin_rst_n_s) begin
            capture = 1'b1;
            ld_nxt = LD_RUN;
          end
        end
        LD_RUN: begin
          if (!pin_rst_n_s) begin
            ld_nxt = LD_HOLD;
          end
        end
      endcase
    end
    // only a capture moves the latched straps; pin activity otherwise ignored
    strap_nxt = capture ? strap_now : strap_r;
    load_nxt = clk_en ? capture : load_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ld_r <= LD_POR;
      settle_r <= 2'h0;
      strap_r <= '{iface: 1'b0, mode: MODE_RST, addr: ADDR_RST};
      load_r <= 1'b0;
    end else begin
      ld_r <= ld_nxt;
      settle_r <= settle_nxt;
      strap_r <= strap_nxt;
      load_r <= load_nxt;
    end
  end

  // AXI4-Lite handshakes; write fires once both address and data are held
  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    do_write = 1'b0;
    if (clk_en) begin
      if (s_axi_awvalid && awready_r) begin
        aw_full_nxt = 1'b1;
        awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
        w_full_nxt = 1'b1;
        wdata_nxt = s_axi_wdata;
        wstrb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_nxt = 1'b0;
      end
      if (aw_full_r && w_full_r && !bvalid_r) begin
        do_write = addr_mapped(awaddr_r);
        bvalid_nxt = 1'b1;
        bresp_nxt = addr_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        aw_full_nxt = 1'b0;
        w_full_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r) begin
        arready_nxt = 1'b0;
        rvalid_nxt = 1'b1;
        rdata_nxt = reg_word(s_axi_araddr, ctrl4_r, adv4_r, saddr_r, smode_r, iface_r, strap_r);
        rresp_nxt = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_nxt = 1'b0;
        arready_nxt = 1'b1;
      end
    end
    // ready only while the holding slot is empty
    awready_nxt = !aw_full_nxt;
    wready_nxt = !w_full_nxt;
    wr_word = merge_bytes(reg_word(awaddr_r, ctrl4_r, adv4_r, saddr_r, smode_r, iface_r, strap_r),
                          wdata_r, wstrb_r);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // register contents: strap load wins over a software write in the same cycle for each field that the mode loads
  always_comb begin
    ctrl4_nxt = ctrl4_r;
    adv4_nxt = adv4_r;
    saddr_nxt = saddr_r;
    smode_nxt = smode_r;
    iface_nxt = iface_r;
    pdown_nxt = pdown_r;
    soft_rst = 1'b0;
    if (do_write) begin
      unique case (awaddr_r)
        CTRL_OFF: begin
          ctrl4_nxt = {wr_word[CTRL_SPEED_BIT], wr_word[CTRL_ANEN_BIT],
                       wr_word[CTRL_ISO_BIT], wr_word[CTRL_DUPLEX_BIT]};
          soft_rst = wr_word[CTRL_SOFT_RST_BIT]; // self-clearing, reads back zero
        end
        ADV_OFF: adv4_nxt = wr_word[ADV_LSB +: 4];
        SMODE_OFF: begin
          saddr_nxt = wr_word[SMODE_ADDR_LSB +: 5];
          smode_nxt = wr_word[SMODE_MODE_LSB +: 3];
        end
        default: ;
      endcase
    end
    // soft reset reuses the current mode field, straps untouched
    if (soft_rst) begin
      pdown_nxt = (smode_nxt == MODE_PDOWN);
    end
    if (capture) begin
      saddr_nxt = {2'h0, strap_now.addr};
      smode_nxt = strap_now.mode;
      iface_nxt = strap_now.iface;
      pdown_nxt = 1'b0;
      unique case (strap_now.mode)
        MODE_10HD: ctrl4_nxt = CTRL_LD_10HD;
        MODE_10FD: ctrl4_nxt = CTRL_LD_10FD;
        MODE_100HD: ctrl4_nxt = CTRL_LD_100HD;
        MODE_100FD: ctrl4_nxt = CTRL_LD_100FD;
        MODE_AN_100HD, MODE_REPEATER: begin
          ctrl4_nxt = CTRL_LD_AN;
          adv4_nxt = ADV_LD_100HD;
        end
        MODE_PDOWN: pdown_nxt = 1'b1;
        MODE_ALL: begin
          ctrl4_nxt = CTRL_LD_ALL;
          adv4_nxt = ADV_LD_ALL;
        end
      endcase
    end
  end

  // configuration follows the register values, never the pins directly
  always_comb begin
    cfg_nxt.speed_100 = ctrl4_nxt[3];
    cfg_nxt.an_enable = ctrl4_nxt[2];
    cfg_nxt.isolate = ctrl4_nxt[1];
    cfg_nxt.full_duplex = ctrl4_nxt[0];
    cfg_nxt.repeater = (smode_nxt == MODE_REPEATER);
    // half duplex senses carrier on transmit, except in repeater operation
    cfg_nxt.crs_on_tx = !ctrl4_nxt[0] && (smode_nxt != MODE_REPEATER);
    cfg_nxt.powered_down = pdown_nxt;
    cfg_nxt.rmii_mode = iface_nxt;
    cfg_nxt.station_addr = saddr_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl4_r <= CTRL_RST;
      adv4_r <= ADV_RST;
      saddr_r <= 5'h00;
      smode_r <= MODE_RST;
      iface_r <= 1'b0;
      pdown_r <= 1'b0;
      cfg_r <= '0;
    end else if (clk_en) begin
      ctrl4_r <= ctrl4_nxt;
      adv4_r <= adv4_nxt;
      saddr_r <= saddr_nxt;
      smode_r <= smode_nxt;
      iface_r <= iface_nxt;
      pdown_r <= pdown_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // frame address compare against the live station address
  rscl_addr_match u_match (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .frame_valid(mgmt_frame_valid),
    .frame_addr(mgmt_frame_addr),
    .station_addr(saddr_r),
    .match(mgmt_frame_match),
    .miss(mgmt_frame_miss)
  );

  assign cfg = cfg_r;
  assign scrambler_seed = cfg_r.station_addr;
  assign strap_load_pulse = load_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

// *** tb/rscl_board_model.sv ***
// Purpose: board straps and pin reset source in front of the loader
// Assumes: bench asks for strap levels and reset pulses just after aclk edges
// Notes: unstrapped pins fall to their pull-down level
module rscl_board_model (
  input wire logic strapped,
  input wire logic pin_low_req,
  input wire logic [2:0] want_addr,
  input wire logic [2:0] want_mode,
  input wire logic want_iface,
  output logic external_reset_pin_n,
  output logic [2:0] address_straps,
  output logic [2:0] mode_straps,
  output logic interface_select_strap
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-downs win when no resistor is fitted, so an open board reads all zero
  always_comb begin
    external_reset_pin_n = !pin_low_req;
    address_straps = strapped ? want_addr : 3'h0;
    mode_straps = strapped ? want_mode : 3'h0;
    interface_select_strap = strapped ? want_iface : 1'b0;
  end
endmodule

// *** tb/rscl_top_assertions.sv ***
// Purpose: port-level checks of the strap loader
// Assumes: straps are held steady around every capture
// Notes: all checks are idle while aresetn is low
module rscl_top_assertions
  import rscl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic external_reset_pin_n,
  input wire logic [2:0] address_straps,
  input wire logic [2:0] mode_straps,
  input wire logic interface_select_strap,
  input wire logic mgmt_frame_valid,
  input wire logic [4:0] mgmt_frame_addr,
  input wire logic mgmt_frame_match,
  input wire logic mgmt_frame_miss,
  input wire rscl_pkg::rscl_cfg_type cfg,
  input wire logic [4:0] scrambler_seed,
  input wire logic strap_load_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address, seed and frame answers
  property p_seed; strap_load_pulse |-> scrambler_seed == {2'h0, address_straps}; endproperty
  a_seed: assert property (p_seed) else $error("seed differs from captured address");
  property p_match; mgmt_frame_valid && mgmt_frame_addr == cfg.station_addr |=> mgmt_frame_match && !mgmt_frame_miss;
  endproperty
  a_match: assert property (p_match) else $error("own frame not answered");
  property p_miss; mgmt_frame_valid && mgmt_frame_addr != cfg.station_addr |=> mgmt_frame_miss && !mgmt_frame_match;
  endproperty
  a_miss: assert property (p_miss) else $error("foreign frame answered");
  property p_quiet; !mgmt_frame_valid |=> !mgmt_frame_match && !mgmt_frame_miss; endproperty
  a_quiet: assert property (p_quiet) else $error("frame answer without frame");
  // what a capture must leave behind
  property p_addr; strap_load_pulse |-> cfg.station_addr == {2'h0, address_straps}; endproperty
  a_addr: assert property (p_addr) else $error("captured address wrong");
  property p_iface; strap_load_pulse |-> cfg.rmii_mode == interface_select_strap; endproperty
  a_iface: assert property (p_iface) else $error("captured interface wrong");
  property p_keep; !strap_load_pulse |-> $stable(cfg.rmii_mode); endproperty
  a_keep: assert property (p_keep) else $error("interface changed between captures");
  property p_pdown; strap_load_pulse && mode_straps == MODE_PDOWN |-> cfg.powered_down; endproperty
  a_pdown: assert property (p_pdown) else $error("power-down mode not entered");
  property p_rep; strap_load_pulse && mode_straps == MODE_REPEATER |-> cfg.repeater && cfg.an_enable && !cfg.crs_on_tx;
  endproperty
  a_rep: assert property (p_rep) else $error("repeater setup wrong");
  // sync delay plus one capture cycle fits well inside eight
  property p_pin; $rose(external_reset_pin_n) |-> ##[1:8] strap_load_pulse; endproperty
  a_pin: assert property (p_pin) else $error("no capture after pin reset");
  c_match: cover property (mgmt_frame_valid ##1 mgmt_frame_match);
  c_pdown: cover property (strap_load_pulse && cfg.powered_down);
  c_rep: cover property (strap_load_pulse && cfg.repeater);
endmodule

// *** tb/rscl_top_tb.sv ***
// Purpose: self-checking bench for the strap loader
// Assumes: straps stay steady while a capture is pending
// Notes: registers reached over AXI4-Lite, board side from the model
module rscl_top_tb
  import rscl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, strapped = 1, pin_low_req = 0, want_iface = 1, fv = 0;
  logic [2:0] want_addr = 3'h5, want_mode = 3'h3, addr_s, mode_s;
  logic ext_n, iface_s, match, miss, pulse, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [4:0] fa = 5'h00, seed;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, r;
  rscl_cfg_type cfg;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  always #4 aclk = ~aclk;
  rscl_board_model rscl_board_model_i (.strapped(strapped), .pin_low_req(pin_low_req), .want_addr(want_addr),
    .want_mode(want_mode), .want_iface(want_iface), .external_reset_pin_n(ext_n), .address_straps(addr_s),
    .mode_straps(mode_s), .interface_select_strap(iface_s));
  rscl_top rscl_top_i (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .external_reset_pin_n(ext_n),
    .address_straps(addr_s), .mode_straps(mode_s), .interface_select_strap(iface_s), .mgmt_frame_valid(fv),
    .mgmt_frame_addr(fa), .mgmt_frame_match(match), .mgmt_frame_miss(miss), .cfg(cfg), .scrambler_seed(seed),
    .strap_load_pulse(pulse), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // bus master: hold each channel until its own handshake edge
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_load;
    int n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!pulse && n < 40);
    chk(pulse, 1, "strap load");
  endtask
  task automatic pin_reset(input logic [2:0] m, input logic [2:0] a, input logic i);
    want_mode <= m;
    want_addr <= a;
    want_iface <= i;
    pin_low_req <= 1'b1;
    repeat (6) @(posedge aclk);
    pin_low_req <= 1'b0;
    wait_load();
  endtask
  // answer is a one-cycle pulse one edge after the request is raised
  task automatic frame(input logic [4:0] a, input logic hit);
    fv <= 1'b1;
    fa <= a;
    @(posedge aclk);
    fv <= 1'b0;
    @(posedge aclk);
    chk({match, miss}, {hit, !hit}, "frame answer");
  endtask
  task automatic t_power;
    rd(CTRL_OFF);
    chk({d[13], d[12], d[10], d[8]}, 4'h9, "ctrl at power-on");
    rd(SMODE_OFF);
    chk(d[4:0], 5'h05, "address at power-on");
    chk(d[SMODE_IFACE_BIT], 1, "interface bit");
    chk(seed, 5'h05, "seed");
    $display("test power-on done");
  endtask
  // preload known values so that untouched fields show up as kept
  task automatic t_modes;
    logic [3:0] ec [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hc, 4'hc, 4'h2, 4'hd};
    logic [3:0] ea [8] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h4, 4'h4, 4'h3, 4'hf};
    for (int m = 0; m < 8; m++) begin
      wr(ADV_OFF, 32'h60);
      wr(CTRL_OFF, 32'h400);
      pin_reset(m[2:0], 3'h2, m[0]);
      rd(CTRL_OFF);
      chk({d[13], d[12], d[10], d[8]}, ec[m], "ctrl load");
      chk({cfg.speed_100, cfg.an_enable, cfg.isolate, cfg.full_duplex}, ec[m], "cfg follows ctrl");
      rd(ADV_OFF);
      chk(d[8:5], ea[m], "adv load");
      chk(cfg.powered_down, m == 6, "power-down");
      if (m >= 2 && m <= 5) chk(cfg.crs_on_tx, m == 2 || m == 4, "carrier on transmit");
    end
    $display("test modes done");
  endtask
  // strap change without pin reset must not leak in through soft reset
  task automatic t_soft;
    pin_reset(3'h6, 3'h2, 1'b0);
    chk(cfg.powered_down, 1, "asleep");
    want_mode <= 3'h3;
    wr(SMODE_OFF, 32'h22);
    wr(CTRL_OFF, 32'hb100);
    rd(CTRL_OFF);
    chk({d[13], d[12], d[10], d[8]}, 4'hd, "ctrl kept");
    chk(cfg.powered_down, 0, "woken");
    rd(SMODE_OFF);
    chk(d[7:5], 3'h1, "mode field kept");
    $display("test soft reset done");
  endtask
  task automatic t_high;
    wr(SMODE_OFF, 32'h3b);
    // lane 1 only: the address byte below it must survive
    wstrb <= 4'h2;
    wr(SMODE_OFF, 32'h0);
    wstrb <= 4'hf;
    frame(5'h1b, 1'b1);
    frame(5'h02, 1'b0);
    chk(seed, 5'h1b, "seed above 7");
    $display("test high address done");
  endtask
  task automatic t_hold;
    want_addr <= 3'h7;
    want_mode <= 3'h0;
    want_iface <= 1'b1;
    repeat (20) @(posedge aclk);
    rd(STRAP_OFF);
    chk(d[8:0], 9'h062, "readback held");
    rd(6'h10);
    chk(r, 2'h2, "unmapped read response");
    chk(d, 32'h0, "unmapped read data");
    wr(6'h14, 32'h1);
    chk(r, 2'h2, "unmapped write");
    strapped <= 1'b0;
    pin_reset(3'h7, 3'h7, 1'b1);
    rd(SMODE_OFF);
    chk({d[SMODE_IFACE_BIT], d[4:0]}, 6'h00, "open board");
    $display("test hold done");
  endtask
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      $display("ERROR %0t timeout", $time);
      results();
    end
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    wait_load();
    t_power();
    t_modes();
    t_soft();
    t_high();
    t_hold();
    results();
  end
endmodule
bind rscl_top rscl_top_assertions rscl_top_assertions_i (.aclk(aclk), .aresetn(aresetn),
  .external_reset_pin_n(external_reset_pin_n), .address_straps(address_straps), .mode_straps(mode_straps),
  .interface_select_strap(interface_select_strap), .mgmt_frame_valid(mgmt_frame_valid),
  .mgmt_frame_addr(mgmt_frame_addr), .mgmt_frame_match(mgmt_frame_match), .mgmt_frame_miss(mgmt_frame_miss),
  .cfg(cfg), .scrambler_seed(scrambler_seed), .strap_load_pulse(strap_load_pulse));
